// file: hdl/ifbs_top.sv
`timescale 1ns/1ps
`default_nettype none
module ifbs_top
    import ifbs_pkg::*;
#(
    parameter logic [15:0] EXT_BASE = EXT_BASE_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Microcode word
    input wire ifbs_ucode_t ucode,
    // Arithmetic board
    input wire logic [15:0] alu_result,
    output logic [15:0] alu_operand,
    output logic [7:0] opcode,
    output logic [15:0] pc,
    output logic busy,
    output logic fetch_done,
    // Memory access sequencer
    output logic mem_req,
    output ifbs_maddr_t maddr,
    input wire logic mem_ack,
    input wire logic [7:0] odd_data,
    input wire logic [7:0] even_data
);

    ifbs_ucode_t pipe;
    logic hold_prev;
    ifbs_state_t state;
    ifbs_kind_t kind;
    logic [15:0] acc_addr;
    logic is_ext;
    logic [7:0] first_byte;
    logic [7:0] mbl;

    logic fetch_go;
    logic cmd_go;
    logic start_acc;
    logic [15:0] next_addr;
    logic next_ext;
    logic done;
    logic [15:0] word;
    logic [7:0] word_hi;
    logic [7:0] word_lo;

    // Microcode pipeline register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pipe <= '{fetch_hold_n: 1'b1, mem_ctl: MC_NOP};
            hold_prev <= 1'b1;
        end else begin
            pipe <= ucode; // R16
            hold_prev <= pipe.fetch_hold_n;
        end
    end

    // Falling edge of hold starts a fetch, only between instructions
    assign fetch_go = (state == S_IDLE) && !pipe.fetch_hold_n && hold_prev; // R1 R14
    assign cmd_go = (state == S_IDLE) && !fetch_go;
    assign start_acc = fetch_go || (cmd_go && ((pipe.mem_ctl == MC_XFER16) ||
                                               (pipe.mem_ctl == MC_RADDR)));
    // Fetch and word operand both address memory with the counter
    assign next_addr = (fetch_go || (pipe.mem_ctl == MC_XFER16)) ? pc : alu_result; // R2 R6
    assign next_ext = (next_addr >= EXT_BASE);

    assign done = mem_ack && (((state == S_MEM1) && !is_ext) || (state == S_MEM2));

    // Byte lane steering into the 16-bit word
    always_comb begin
        if (is_ext) begin
            word = {first_byte, even_data}; // R11
        end else if (acc_addr[0]) begin
            word = {odd_data, even_data}; // R12 R13
        end else begin
            word = {even_data, odd_data}; // R12
        end
    end
    assign word_hi = word[15:8];
    assign word_lo = word[7:0];

    // Access sequencing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= S_IDLE;
            kind <= K_FETCH;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start_acc) begin
                        state <= S_MEM1;
                        if (fetch_go) begin
                            kind <= K_FETCH;
                        end else if (pipe.mem_ctl == MC_XFER16) begin
                            kind <= K_OPND;
                        end else begin
                            kind <= K_READ;
                        end
                    end
                end
                S_MEM1: begin
                    if (mem_ack) begin
                        state <= is_ext ? S_MEM2 : S_IDLE;
                    end
                end
                S_MEM2: begin
                    if (mem_ack) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Address buses toward the sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_addr <= PC_RST;
            is_ext <= 1'b0;
            mem_req <= 1'b0;
            maddr <= '0;
        end else if (start_acc) begin
            acc_addr <= next_addr;
            is_ext <= next_ext;
            mem_req <= 1'b1;
            maddr.odd_addr <= next_addr; // R9
            maddr.ext_addr <= next_addr; // R10
            maddr.ext_en <= next_ext;
            if (next_ext) begin
                maddr.even_addr <= next_addr; // R10
            end else begin
                maddr.even_addr <= next_addr + PC_STEP1; // R9
            end
        end else if ((state == S_MEM1) && mem_ack && is_ext) begin
            // Second external byte at the next address
            maddr.ext_addr <= maddr.ext_addr + PC_STEP1; // R10
            maddr.even_addr <= maddr.even_addr + PC_STEP1;
            maddr.ext_en <= 1'b1;
        end else if (done) begin
            mem_req <= 1'b0;
            maddr.ext_en <= 1'b0;
        end
    end

    // First external byte is held for the odd lane
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            first_byte <= ZERO_HI;
        end else if ((state == S_MEM1) && mem_ack && is_ext) begin
            first_byte <= even_data; // R11
        end
    end

    // Opcode register and memory byte latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            opcode <= ZERO_HI;
            mbl <= ZERO_HI;
        end else if (done && (kind == K_FETCH)) begin
            opcode <= word_hi; // R3
            mbl <= word_lo; // R3 R4
        end
    end

    // Program counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc <= PC_RST;
        end else if (done) begin
            if (kind == K_FETCH) begin
                pc <= pc + PC_STEP1; // R5 R18
            end else if (kind == K_OPND) begin
                pc <= pc + PC_STEP2; // R8 R18
            end
        end else if (cmd_go) begin
            unique case (pipe.mem_ctl) // R17
                MC_INC: pc <= pc + PC_STEP1; // R17 R18
                MC_ALU2PC: pc <= alu_result; // R15
                MC_XFER8: pc <= pc + PC_STEP1; // R7
                MC_NOP, MC_PC2ALU, MC_XFER16, MC_RADDR, MC_WADDR: pc <= pc;
            endcase
        end
    end

    // Latch feeding the arithmetic unit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alu_operand <= '0;
        end else if (done && (kind != K_FETCH)) begin
            alu_operand <= word; // R8 R15
        end else if (cmd_go) begin
            if (pipe.mem_ctl == MC_PC2ALU) begin
                alu_operand <= pc; // R17
            end else if (pipe.mem_ctl == MC_XFER8) begin
                alu_operand <= {ZERO_HI, mbl}; // R7
            end
        end
    end

    // Status toward microcode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy <= 1'b0;
            fetch_done <= 1'b0;
        end else begin
            busy <= start_acc || (busy && !done); // R14
            fetch_done <= done && (kind == K_FETCH);
        end
    end

    property p_fetch_start;
        @(posedge sys_clk) disable iff (rst)
        (state == S_IDLE) && $fell(pipe.fetch_hold_n) |=> mem_req && busy;
    endproperty
    a_fetch_start: assert property (p_fetch_start) else $error("fetch did not start"); // R1

    property p_fetch_addr;
        @(posedge sys_clk) disable iff (rst)
        fetch_go |=> (maddr.odd_addr == $past(pc)) && (kind == K_FETCH);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong"); // R2

    // Opcode and byte latch follow the lane rules, not the internal word mux
    property p_opcode;
        @(posedge sys_clk) disable iff (rst)
        done && (kind == K_FETCH) |=>
            (opcode == $past(is_ext ? first_byte : (acc_addr[0] ? odd_data : even_data))) &&
            (mbl == $past(is_ext ? even_data : (acc_addr[0] ? even_data : odd_data)));
    endproperty
    a_opcode: assert property (p_opcode) else $error("opcode or byte latch wrong"); // R3

    property p_pc_fetch;
        @(posedge sys_clk) disable iff (rst)
        fetch_done |-> pc == $past(pc) + PC_STEP1;
    endproperty
    a_pc_fetch: assert property (p_pc_fetch) else $error("counter not advanced"); // R5

    property p_imm8;
        @(posedge sys_clk) disable iff (rst)
        cmd_go && (pipe.mem_ctl == MC_XFER8) |=>
            (alu_operand == {ZERO_HI, $past(mbl)}) && (pc == $past(pc) + PC_STEP1) && !busy;
    endproperty
    a_imm8: assert property (p_imm8) else $error("byte immediate wrong"); // R7

    property p_imm16;
        @(posedge sys_clk) disable iff (rst)
        done && (kind == K_OPND) |=> (alu_operand == $past(word)) &&
                                     (pc == $past(pc) + PC_STEP2);
    endproperty
    a_imm16: assert property (p_imm16) else $error("word immediate wrong"); // R8

    property p_int_steer;
        @(posedge sys_clk) disable iff (rst)
        start_acc && !next_ext |=> (maddr.even_addr == maddr.odd_addr + PC_STEP1) &&
                                   !maddr.ext_en;
    endproperty
    a_int_steer: assert property (p_int_steer) else $error("internal steering wrong"); // R9

    property p_ext_second;
        @(posedge sys_clk) disable iff (rst)
        (state == S_MEM1) && mem_ack && is_ext |=>
            (maddr.ext_addr == $past(maddr.ext_addr) + PC_STEP1) && maddr.ext_en &&
            (first_byte == $past(even_data)) && (state == S_MEM2);
    endproperty
    a_ext_second: assert property (p_ext_second) else $error("external second byte wrong"); // R10

    // While an access runs, nothing from microcode may disturb addresses or counter
    property p_no_refetch;
        @(posedge sys_clk) disable iff (rst)
        busy && !done && !((state == S_MEM1) && mem_ack && is_ext) |=>
            $stable(maddr) && $stable(pc) && $stable(opcode) && mem_req;
    endproperty
    a_no_refetch: assert property (p_no_refetch) else $error("fetch while busy"); // R14

    property p_ext_start;
        @(posedge sys_clk) disable iff (rst)
        start_acc && next_ext |=> maddr.ext_en && mem_req &&
            (maddr.ext_addr == $past(next_addr)) && (maddr.even_addr == maddr.ext_addr);
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("external start wrong"); // R10

    property p_fetch_pulse;
        @(posedge sys_clk) disable iff (rst)
        fetch_done |=> !fetch_done;
    endproperty
    a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch done too long"); // R3

    // A read at an arithmetic address leaves the counter alone
    property p_read_keep_pc;
        @(posedge sys_clk) disable iff (rst)
        done && (kind == K_READ) |=> $stable(pc) && !mem_req && !busy;
    endproperty
    a_read_keep_pc: assert property (p_read_keep_pc) else $error("read moved counter"); // R17

    c_fetch: cover property (@(posedge sys_clk) disable iff (rst) fetch_go ##[1:20] fetch_done);
    c_ext: cover property (@(posedge sys_clk) disable iff (rst)
        (state == S_MEM2) && mem_ack && (kind == K_OPND));
    c_imm8: cover property (@(posedge sys_clk) disable iff (rst)
        fetch_done ##[1:10] (cmd_go && (pipe.mem_ctl == MC_XFER8)));
    c_raddr: cover property (@(posedge sys_clk) disable iff (rst)
        done && (kind == K_READ));

endmodule : ifbs_top
`default_nettype wire

// file: hdl/ifbs_pkg.sv
// Summary of operation
// R1: A fetch starts when the fetch hold line from microcode goes low.
// R2: Fetch address is the program counter, internal ROM or backpack space.
// R3: Fetch reads two bytes: upper to opcode, lower to memory byte latch.
// R4: For one-byte instructions the latched lower byte is simply left unused.
// R5: After a fetch the program counter advances by one.
// R6: Three-byte instructions drop the latched byte and read one 16-bit word.
// R7: Two-byte immediate sends zero-extended latched byte to arithmetic, counter plus one.
// R8: Three-byte immediate reads 16 bits at counter into arithmetic latch, counter plus two.
// R9: Internal access drives address on odd bus and address plus one on even.
// R10: External access uses even bus and external lines, incremented for second byte.
// R11: External 16-bit read: first byte on odd lane, second on even lane.
// R12: Even and odd bytes take opposite halves of the word; lanes may swap.
// R13: The 16-bit path splits into separate 8-bit odd and even buses.
// R14: Order is fetch, decode, execute, interrupts, fetch; no fetch while busy.
// R15: Separate 16-bit buses carry data into and results out of arithmetic.
// R16: Each microcode word is captured in a pipeline register.
// R17: Memory control field decodes eight operations, nop through write address; here write address starts no access and leaves everything unchanged, like nop.
// R18: Program counter is 16 bits and wraps when incremented.
package ifbs_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] EXT_BASE_DEF = 16'h8000;
    localparam logic [15:0] PC_STEP1 = 16'h0001;
    localparam logic [15:0] PC_STEP2 = 16'h0002;
    localparam logic [7:0] ZERO_HI = 8'h00;
    localparam logic [2:0] MC_NOP = 3'h0;
    localparam logic [2:0] MC_INC = 3'h1;
    localparam logic [2:0] MC_PC2ALU = 3'h2;
    localparam logic [2:0] MC_ALU2PC = 3'h3;
    localparam logic [2:0] MC_XFER8 = 3'h4;
    localparam logic [2:0] MC_XFER16 = 3'h5;
    localparam logic [2:0] MC_RADDR = 3'h6;
    localparam logic [2:0] MC_WADDR = 3'h7;
    typedef struct packed {
        logic fetch_hold_n;
        logic [2:0] mem_ctl;
    } ifbs_ucode_t;
    typedef struct packed {
        logic [15:0] odd_addr;
        logic [15:0] even_addr;
        logic [15:0] ext_addr;
        logic ext_en;
    } ifbs_maddr_t;
    typedef enum logic [1:0] {S_IDLE, S_MEM1, S_MEM2} ifbs_state_t;
    typedef enum logic [1:0] {K_FETCH, K_OPND, K_READ} ifbs_kind_t;
endpackage : ifbs_pkg

// file: sim/ifbs_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifbs_seq_model
    import ifbs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Command side
    input wire logic mem_req,
    input wire ifbs_maddr_t maddr,
    input wire logic [3:0] lat,
    // Byte buses
    output logic mem_ack,
    output logic [7:0] odd_data,
    output logic [7:0] even_data
);
    logic [3:0] cnt;
    function automatic logic [7:0] m8(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : m8
    // Lanes flip every idle cycle so stale bytes never look valid
    always_ff @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        odd_data <= ~odd_data;
        even_data <= ~even_data;
        cnt <= 4'h0;
        if (rst) begin
            odd_data <= 8'h00;
            even_data <= 8'h00;
        end else if (mem_req && !mem_ack && cnt < lat) begin
            cnt <= cnt + 4'h1;
        end else if (mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            if (maddr.ext_en) begin
                even_data <= m8(maddr.ext_addr);
            end else begin
                odd_data <= m8(maddr.odd_addr[0] ? maddr.odd_addr : maddr.even_addr);
                even_data <= m8(maddr.odd_addr[0] ? maddr.even_addr : maddr.odd_addr);
            end
        end
    end
endmodule : ifbs_seq_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import ifbs_pkg::*;
;
    localparam logic [15:0] EXT = 16'h8000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ifbs_ucode_t ucode = '{1'b1, MC_NOP};
    logic [15:0] alu_result = 16'h0000;
    logic [3:0] lat = 4'h4;
    logic [15:0] alu_operand;
    logic [15:0] pc;
    logic [7:0] opcode;
    logic [7:0] odd_data;
    logic [7:0] even_data;
    logic busy;
    logic fetch_done;
    logic mem_req;
    logic mem_ack;
    ifbs_maddr_t maddr;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    always #50 sys_clk = ~sys_clk;
    ifbs_top #(.EXT_BASE(EXT)) dut (.sys_clk(sys_clk), .rst(rst), .ucode(ucode),
        .alu_result(alu_result), .alu_operand(alu_operand), .opcode(opcode), .pc(pc),
        .busy(busy), .fetch_done(fetch_done), .mem_req(mem_req), .maddr(maddr),
        .mem_ack(mem_ack), .odd_data(odd_data), .even_data(even_data));
    ifbs_seq_model seq (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .maddr(maddr),
        .lat(lat), .mem_ack(mem_ack), .odd_data(odd_data), .even_data(even_data));
    function automatic logic [7:0] m8(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : m8
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic cmd(input logic [2:0] c, input logic [15:0] res);
        @(posedge sys_clk);
        ucode.mem_ctl <= c;
        alu_result <= res;
        @(posedge sys_clk);
        ucode.mem_ctl <= MC_NOP;
        @(posedge sys_clk);
        #1;
    endtask : cmd
    task automatic access(input logic f, input logic [2:0] c, input logic [15:0] res,
                          input logic [15:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        ucode.fetch_hold_n <= 1'b1;
        @(posedge sys_clk);
        if (f) ucode.fetch_hold_n <= 1'b0;
        else ucode.mem_ctl <= c;
        alu_result <= res;
        @(posedge sys_clk);
        ucode.mem_ctl <= MC_NOP;
        #1;
        while (mem_req !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("mem_req", 16'h0001, {15'h0000, mem_req});
        chk("busy", 16'h0001, {15'h0000, busy});
        if (a >= EXT) begin
            chk("ext_en", 16'h0001, {15'h0000, maddr.ext_en});
            chk("ext_addr", a, maddr.ext_addr);
            chk("even_addr ext", a, maddr.even_addr);
        end else begin
            chk("odd_addr", a, maddr.odd_addr);
            chk("even_addr", a + 16'h0001, maddr.even_addr);
            chk("ext_en int", 16'h0000, {15'h0000, maddr.ext_en});
        end
        // A command slipped in while busy must be dropped
        if (lat > 4'h2) begin
            @(posedge sys_clk);
            ucode.mem_ctl <= MC_INC;
            @(posedge sys_clk);
            ucode.mem_ctl <= MC_NOP;
            #1;
        end
        while (mem_ack !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        #1;
        if (a >= EXT) chk("ext_addr 2", a + 16'h0001, maddr.ext_addr);
        while (busy !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("busy end", 16'h0000, {15'h0000, busy});
        chk("mem_req end", 16'h0000, {15'h0000, mem_req});
        if (f) chk("fetch_done", 16'h0001, {15'h0000, fetch_done});
    endtask : access
    task automatic fetch_at(input logic [15:0] a);
        access(1'b1, MC_NOP, 16'h0000, a);
        chk("opcode", {8'h00, m8(a)}, {8'h00, opcode});
        chk("pc fetch", a + 16'h0001, pc);
        repeat (4) @(posedge sys_clk);
        #1;
        chk("no refetch", 16'h0000, {15'h0000, mem_req});
        chk("fetch_done pulse", 16'h0000, {15'h0000, fetch_done});
    endtask : fetch_at
    task automatic test_reset;
        chk("pc reset", PC_RST, pc);
        chk("req reset", 16'h0000, {15'h0000, mem_req});
        chk("busy reset", 16'h0000, {15'h0000, busy});
        chk("maddr reset", 16'h0000, maddr.odd_addr | maddr.even_addr | maddr.ext_addr);
    endtask : test_reset
    task automatic test_imm8(input logic [15:0] a);
        cmd(MC_ALU2PC, a);
        chk("pc load", a, pc);
        fetch_at(a);
        cmd(MC_XFER8, 16'h0000);
        chk("xfer8", {ZERO_HI, m8(a + 16'h0001)}, alu_operand);
        chk("pc xfer8", a + 16'h0002, pc);
    endtask : test_imm8
    task automatic test_imm16(input logic [15:0] a);
        fetch_at(a);
        access(1'b0, MC_XFER16, 16'h0000, a + 16'h0001);
        chk("xfer16", {m8(a + 16'h0001), m8(a + 16'h0002)}, alu_operand);
        chk("pc xfer16", a + 16'h0003, pc);
    endtask : test_imm16
    task automatic test_cmds(input logic [15:0] p);
        cmd(MC_PC2ALU, 16'h0000);
        chk("pc2alu", p, alu_operand);
        cmd(MC_NOP, 16'h5555);
        cmd(MC_WADDR, 16'h5555);
        chk("pc idle", p, pc);
    endtask : test_cmds
    task automatic test_raddr(input logic [15:0] a, input logic [15:0] p);
        access(1'b0, MC_RADDR, a, a);
        chk("raddr", {m8(a), m8(a + 16'h0001)}, alu_operand);
        chk("pc raddr", p, pc);
    endtask : test_raddr
    task automatic test_wrap;
        cmd(MC_ALU2PC, 16'hFFFF);
        cmd(MC_INC, 16'h0000);
        chk("pc wrap1", 16'h0000, pc);
        @(posedge sys_clk);
        lat <= 4'h0;
        cmd(MC_ALU2PC, 16'hFFFE);
        access(1'b0, MC_XFER16, 16'h0000, 16'hFFFE);
        chk("ext word", {m8(16'hFFFE), m8(16'hFFFF)}, alu_operand);
        chk("pc wrap2", 16'h0000, pc);
    endtask : test_wrap
    task automatic test_ext_fetch(input logic [15:0] a);
        cmd(MC_ALU2PC, a);
        fetch_at(a);
    endtask : test_ext_fetch
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        test_reset();
        test_imm8(16'h1234);
        test_imm16(16'h1236);
        test_cmds(16'h1239);
        test_raddr(16'h0040, 16'h1239);
        test_wrap();
        test_ext_fetch(16'h9001);
        finish_test();
    end
endmodule : tb
`default_nettype wire
